// >>> logic/acm_defines.svh
// Register map, field positions, reset values and masks of the converter
// control block. Holds definitions only; included by its bare name.
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH
`define ACM_ADDR_ENABLE   32'hffff0504
`define ACM_ADDR_MODE     32'hffff0508
`define ACM_ADDR_STATUS   32'hffff0580
`define ACM_ADDR_CLEAR    32'hffff0584
`define ACM_ADDR_CALRES   32'hffff0588
`define ACM_ENABLE_RESET  8'h00
`define ACM_ENABLE_WMASK  8'h5b
`define ACM_MODE_RESET    8'h03
`define ACM_MODE_WMASK    8'hbf
`define ACM_STATUS_RESET  9'h000
`define ACM_STATUS_W      9
`define ACM_CAL_W         24
`define ACM_BIT_PRIM_RDY  0
`define ACM_BIT_AUX_RDY   1
`define ACM_BIT_OVR       3
`define ACM_BIT_PTHR      4
`define ACM_BIT_ATHR      6
`define ACM_BIT_CAL_RDY   8
`define ACM_MODE_CLKSEL   7
`define ACM_MODE_LPEN     5
`endif

// >>> logic/acm_pkg.sv
// Types of the converter control block: operation and power mode codes.
// Assumes nothing of its surroundings.
package acm_pkg;
   typedef enum logic [2:0] {
      ACM_OP_POWER_DOWN  = 3'h0,
      ACM_OP_CONTINUOUS  = 3'h1,
      ACM_OP_SINGLE      = 3'h2,
      ACM_OP_IDLE        = 3'h3,
      ACM_OP_SELF_OFFSET = 3'h4,
      ACM_OP_SELF_GAIN   = 3'h5,
      ACM_OP_SYS_ZERO    = 3'h6,
      ACM_OP_SYS_FULL    = 3'h7
   } acm_op_mode_t;
   typedef enum logic [1:0] {
      ACM_PM_NORMAL     = 2'h0,
      ACM_PM_LOW        = 2'h1,
      ACM_PM_NORMAL_ALT = 2'h2,
      ACM_PM_LOW_PLUS   = 2'h3
   } acm_power_mode_t;
endpackage

// >>> logic/acm_regs_if.sv
// Carrier between the control top and its two register modules.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`include "acm_defines.svh"
interface acm_regs_if (
   input wire logic clk,
   input wire logic rst_n
);
   logic                     ce;
   logic                     wr;
   logic [`ACM_STATUS_W-1:0] wdata;
   logic                     sel_enable;
   logic                     sel_clear;
   logic                     sel_mode;
   logic [`ACM_STATUS_W-1:0] hw_set;
   logic [`ACM_STATUS_W-1:0] hw_clr;
   logic                     go_idle;
   logic [`ACM_STATUS_W-1:0] status;
   logic [7:0]               enable;
   logic [7:0]               mode;
   modport irq (input clk, rst_n, ce, wr, wdata, sel_enable, sel_clear,
                input hw_set, hw_clr, output status, enable);
   modport mode_reg (input clk, rst_n, ce, wr, wdata, sel_mode, go_idle,
                     output mode);
endinterface

// >>> logic/acm_irq.sv
// Sticky status flags and the interrupt enable register.
// Assumes set and clear requests arrive on the same clock.
`timescale 1ns/1ps
`include "acm_defines.svh"
module acm_irq (
   acm_regs_if.irq rf
);
   logic [`ACM_STATUS_W-1:0] next_status;
   logic [7:0]               next_enable;

   // A set arriving with its clear wins, so no event is lost.
   always_comb
   begin
      next_status = rf.status;
      next_enable = rf.enable;
      if (rf.ce)
      begin
         next_status = (rf.status & ~(rf.hw_clr |
            ((rf.wr && rf.sel_clear) ? rf.wdata : `ACM_STATUS_RESET)))
            | rf.hw_set;
         if (rf.wr && rf.sel_enable)
            next_enable = rf.wdata[7:0] & `ACM_ENABLE_WMASK;
      end
   end

   always_ff @(posedge rf.clk or negedge rf.rst_n)
   begin
      if (!rf.rst_n)
      begin
         rf.status <= `ACM_STATUS_RESET;
         rf.enable <= `ACM_ENABLE_RESET;
      end
      else
      begin
         rf.status <= next_status;
         rf.enable <= next_enable;
      end
   end
endmodule // acm_irq

// >>> logic/acm_mode.sv
// Converter mode register with hardware return to idle.
// Assumes the return request is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`include "acm_defines.svh"
module acm_mode (
   acm_regs_if.mode_reg rf
);
   logic [7:0] next_mode;

   // A software write in the same cycle beats the return to idle.
   always_comb
   begin
      next_mode = rf.mode;
      if (rf.ce && rf.wr && rf.sel_mode)
         next_mode = rf.wdata[7:0] & `ACM_MODE_WMASK;
      else if (rf.ce && rf.go_idle)
         next_mode = {rf.mode[7:3], acm_pkg::ACM_OP_IDLE};
   end

   always_ff @(posedge rf.clk or negedge rf.rst_n)
   begin
      if (!rf.rst_n)
         rf.mode <= `ACM_MODE_RESET;
      else
         rf.mode <= next_mode;
   end
endmodule // acm_mode

// >>> logic/acm_ctrl_top.sv
// Converter control top: register port, status events, mode decode and
// the converter interrupt request.
// Assumes converter datapath events come from logic on sys_clk_in.
`timescale 1ns/1ps
`include "acm_defines.svh"
module acm_ctrl_top (
   input  wire logic                  sys_clk_in,
   input  wire logic                  arst_n_in,
   input  wire logic                  ce_in,
   input  wire logic [31:0]           addr_in,
   input  wire logic [31:0]           wr_data_in,
   input  wire logic                  wr_in,
   input  wire logic                  rd_in,
   input  wire logic                  prim_result_wr_in,
   input  wire logic                  aux_result_wr_in,
   input  wire logic                  prim_result_rd_in,
   input  wire logic                  aux_result_rd_in,
   input  wire logic                  prim_overrange_in,
   input  wire logic                  prim_threshold_in,
   input  wire logic                  accum_threshold_in,
   input  wire logic                  cal_done_in,
   input  wire logic [`ACM_CAL_W-1:0] cal_result_in,
   output logic      [31:0]           rd_data_out,
   output logic                       irq_out,
   output logic                       conv_clk_fast_out,
   output logic                       lp_enable_out,
   output logic                       amp_off_out,
   output logic      [2:0]            op_mode_out,
   output logic                       powerdown_out,
   output logic                       adc_hold_out,
   output logic                       cal_active_out
);

   // ---------------------------------------------------------------
   // Register modules
   // ---------------------------------------------------------------
   acm_regs_if rf (
      .clk   (sys_clk_in),
      .rst_n (arst_n_in)
   );

   acm_irq u_irq (
      .rf (rf)
   );

   acm_mode u_mode (
      .rf (rf)
   );

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   logic                    sel_enable;
   logic                    sel_mode;
   logic                    sel_status;
   logic                    sel_clear;
   logic                    sel_calres;
   acm_pkg::acm_op_mode_t   op_mode;
   acm_pkg::acm_power_mode_t power_mode;

   assign sel_enable = (addr_in == `ACM_ADDR_ENABLE);
   assign sel_mode   = (addr_in == `ACM_ADDR_MODE);
   assign sel_status = (addr_in == `ACM_ADDR_STATUS);
   assign sel_clear  = (addr_in == `ACM_ADDR_CLEAR);
   assign sel_calres = (addr_in == `ACM_ADDR_CALRES);
   assign op_mode    = acm_pkg::acm_op_mode_t'(rf.mode[2:0]);
   assign power_mode = acm_pkg::acm_power_mode_t'(rf.mode[4:3]);

   assign rf.ce         = ce_in;
   assign rf.wr         = wr_in;
   assign rf.wdata      = wr_data_in[`ACM_STATUS_W-1:0];
   assign rf.sel_enable = sel_enable;
   assign rf.sel_clear  = sel_clear;
   assign rf.sel_mode   = sel_mode;

   // ---------------------------------------------------------------
   // Status events
   // ---------------------------------------------------------------
   // The auxiliary ready flag needs an auxiliary result read followed
   // by a primary result read, so the first read is remembered here.
   logic                  aux_read_seen;
   logic                  next_aux_read_seen;
   logic [`ACM_CAL_W-1:0] cal_result;
   logic [`ACM_CAL_W-1:0] next_cal_result;
   logic                  cal_end;
   logic                  single_end;

   assign cal_end    = cal_done_in && rf.mode[2];
   assign single_end = prim_result_wr_in &&
                       (op_mode == acm_pkg::ACM_OP_SINGLE);
   assign rf.go_idle = cal_end || single_end;

   always_comb
   begin
      rf.hw_set = `ACM_STATUS_RESET;
      rf.hw_set[`ACM_BIT_PRIM_RDY] = prim_result_wr_in || cal_end;
      rf.hw_set[`ACM_BIT_AUX_RDY]  = aux_result_wr_in;
      rf.hw_set[`ACM_BIT_OVR]      = prim_overrange_in;
      rf.hw_set[`ACM_BIT_PTHR]     = prim_threshold_in;
      rf.hw_set[`ACM_BIT_ATHR]     = accum_threshold_in;
      rf.hw_set[`ACM_BIT_CAL_RDY]  = cal_end;
      rf.hw_clr = `ACM_STATUS_RESET;
      rf.hw_clr[`ACM_BIT_PRIM_RDY] = prim_result_rd_in;
      rf.hw_clr[`ACM_BIT_AUX_RDY]  = prim_result_rd_in &&
                                     (aux_read_seen || aux_result_rd_in);
   end

   always_comb
   begin
      next_aux_read_seen = aux_read_seen;
      next_cal_result    = cal_result;
      if (ce_in)
      begin
         if (prim_result_rd_in)
            next_aux_read_seen = 1'b0;
         else if (aux_result_rd_in)
            next_aux_read_seen = 1'b1;
         if (cal_end)
            next_cal_result = cal_result_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         aux_read_seen <= 1'b0;
         cal_result    <= {`ACM_CAL_W{1'b0}};
      end
      else
      begin
         aux_read_seen <= next_aux_read_seen;
         cal_result    <= next_cal_result;
      end
   end

   // ---------------------------------------------------------------
   // Read port and registered outputs
   // ---------------------------------------------------------------
   logic [31:0] next_rd_data;
   logic        next_irq;
   logic        next_clk_fast;
   logic        next_lp_enable;
   logic        next_amp_off;
   logic [2:0]  next_op_mode;
   logic        next_powerdown;
   logic        next_hold;
   logic        next_cal_active;

   always_comb
   begin
      next_rd_data = 32'h0000_0000;
      if (rd_in)
      begin
         // Reserved and unmapped locations read as zero.
         if (sel_enable)
            next_rd_data[7:0] = rf.enable;
         else if (sel_mode)
            next_rd_data[7:0] = rf.mode;
         else if (sel_status)
            next_rd_data[`ACM_STATUS_W-1:0] = rf.status;
         else if (sel_calres)
            next_rd_data[`ACM_CAL_W-1:0] = cal_result;
      end
      next_irq        = |(rf.status[7:0] & rf.enable);
      next_clk_fast   = rf.mode[`ACM_MODE_CLKSEL];
      // The low-power enable only matters in the two low-power modes.
      next_lp_enable  = power_mode[0] && rf.mode[`ACM_MODE_LPEN];
      next_amp_off    = (power_mode == acm_pkg::ACM_PM_LOW_PLUS);
      next_op_mode    = op_mode;
      next_powerdown  = (op_mode == acm_pkg::ACM_OP_POWER_DOWN);
      next_hold       = (op_mode == acm_pkg::ACM_OP_IDLE);
      next_cal_active = rf.mode[2];
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rd_data_out       <= 32'h0000_0000;
         irq_out           <= 1'b0;
         conv_clk_fast_out <= 1'b0;
         lp_enable_out     <= 1'b0;
         amp_off_out       <= 1'b0;
         op_mode_out       <= 3'h3;
         powerdown_out     <= 1'b0;
         adc_hold_out      <= 1'b1;
         cal_active_out    <= 1'b0;
      end
      else if (ce_in)
      begin
         rd_data_out       <= next_rd_data;
         irq_out           <= next_irq;
         conv_clk_fast_out <= next_clk_fast;
         lp_enable_out     <= next_lp_enable;
         amp_off_out       <= next_amp_off;
         op_mode_out       <= next_op_mode;
         powerdown_out     <= next_powerdown;
         adc_hold_out      <= next_hold;
         cal_active_out    <= next_cal_active;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   logic seen_edge;

   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         seen_edge <= 1'b0;
      else
         seen_edge <= 1'b1;
   end

   sequence s_mode_write;
      ce_in && wr_in && sel_mode;
   endsequence

   sequence s_mode_read;
      ce_in && rd_in && sel_mode && !wr_in;
   endsequence

   sequence s_enable_write;
      ce_in && wr_in && sel_enable;
   endsequence

   sequence s_enable_read;
      ce_in && rd_in && sel_enable && !wr_in;
   endsequence

   sequence s_cal_end;
      ce_in && cal_end && !(wr_in && sel_mode);
   endsequence

   a_enable_reset_zero: assert property (
      !seen_edge |-> rf.enable == `ACM_ENABLE_RESET)
      else $error("Enable register not zero after reset.");

   a_mode_reset_value: assert property (
      !seen_edge |-> rf.mode == `ACM_MODE_RESET)
      else $error("Mode register not at reset value.");

   a_enable_readback: assert property (
      s_enable_write ##1 s_enable_read
      |=> rd_data_out[7:0] == ($past(wr_data_in[7:0], 2) & 8'h5b))
      else $error("Enable bits not read back in place.");

   a_mode_readback: assert property (
      s_mode_write ##1 s_mode_read
      |=> rd_data_out == {24'h00_0000,
                          $past(wr_data_in[7:0], 2) & 8'hbf})
      else $error("Mode register read back wrong.");

   a_op_code_held: assert property (
      s_mode_write |=> rf.mode[2:0] == $past(wr_data_in[2:0]))
      else $error("Operation code not stored.");

   a_irq_raise: assert property (
      ce_in && (|(rf.status[7:0] & rf.enable)) |=> irq_out)
      else $error("Enabled flag set but no request.");

   a_irq_drop: assert property (
      ce_in && !(|(rf.status[7:0] & rf.enable)) |=> !irq_out)
      else $error("Request high with no enabled flag.");

   a_accum_masked: assert property (
      ce_in && rf.status[7:0] == 8'h40 && !rf.enable[6] |=> !irq_out)
      else $error("Masked accumulator flag raised request.");

   a_pthresh_masked: assert property (
      ce_in && rf.status[7:0] == 8'h10 && !rf.enable[4] |=> !irq_out)
      else $error("Masked threshold flag raised request.");

   a_ovr_gate: assert property (
      ce_in && rf.status[7:0] == 8'h08 |=> irq_out == $past(rf.enable[3]))
      else $error("Overrange flag not gated by bit 3.");

   a_aux_ready_gate: assert property (
      ce_in && rf.status[7:0] == 8'h02 |=> irq_out == $past(rf.enable[1]))
      else $error("Auxiliary ready not gated by bit 1.");

   a_prim_ready_gate: assert property (
      ce_in && rf.status[7:0] == 8'h01 |=> irq_out == $past(rf.enable[0]))
      else $error("Primary ready not gated by bit 0.");

   a_clock_select: assert property (
      ce_in |=> conv_clk_fast_out == $past(rf.mode[7]))
      else $error("Clock select output does not follow bit 7.");

   a_lp_ignored_normal: assert property (
      ce_in && rf.mode[4:3] == 2'b00 |=> !lp_enable_out)
      else $error("Low-power enable acted in normal mode.");

   a_power_decode: assert property (
      ce_in |=> amp_off_out == ($past(rf.mode[4:3]) == 2'b11)
                && lp_enable_out == ($past(rf.mode[3]) && $past(rf.mode[5])))
      else $error("Power mode decoded wrongly.");

   a_op_decode: assert property (
      ce_in |=> powerdown_out == ($past(rf.mode[2:0]) == 3'h0)
                && adc_hold_out == ($past(rf.mode[2:0]) == 3'h3))
      else $error("Operation code decoded wrongly.");

   a_cal_end_idle: assert property (
      s_cal_end |=> rf.mode[2:0] == 3'h3 && rf.status[8] && rf.status[0]
                    && cal_result == $past(cal_result_in))
      else $error("Calibration end not handled.");

   a_prim_ready_set: assert property (
      ce_in && prim_result_wr_in |=> rf.status[0])
      else $error("Primary ready not set by new result.");

   a_prim_ready_clear: assert property (
      ce_in && prim_result_rd_in && !prim_result_wr_in && !cal_end
      |=> !rf.status[0])
      else $error("Primary ready not cleared by result read.");

endmodule // acm_ctrl_top

// >>> testbench/acm_ctrl_top_tb_top.sv
// Self-checking bench for the converter control top: register port,
// mode decode, status events and the interrupt request.
// Assumes the design files under logic/ are compiled first.
`timescale 1ns/1ps
`include "acm_defines.svh"
module acm_ctrl_top_tb_top;
   // ------------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------------
   typedef struct {
      logic [7:0] wv;
      logic [7:0] rv;
      logic [8:0] ov;
   } acm_row_t;
   logic        sys_clk_in = 1'b0;
   logic        arst_n_in  = 1'b0;
   logic        ce_in      = 1'b1;
   logic [31:0] addr_in    = 32'h0;
   logic [31:0] wr_data_in = 32'h0;
   logic        wr_in      = 1'b0;
   logic        rd_in      = 1'b0;
   logic [7:0]  ev         = 8'h00;
   logic [23:0] cal_res    = 24'h0;
   logic [31:0] rd_data_out;
   logic        irq_out;
   logic        fast;
   logic        lp;
   logic        amp;
   logic [2:0]  op;
   logic        pd;
   logic        hold;
   logic        cal;
   logic [8:0]  outs;
   int          n_errors  = 0;
   int          tests_run = 0;
   int          src [5]   = '{0, 1, 3, 4, 6};
   acm_row_t    rows [8]  = '{
      '{8'h80, 8'h80, 9'h104}, '{8'ha9, 8'ha9, 9'h188},
      '{8'h3a, 8'h3a, 9'h0d0}, '{8'h63, 8'h23, 9'h01a},
      '{8'h14, 8'h14, 9'h021}, '{8'h25, 8'h25, 9'h029},
      '{8'h1e, 8'h1e, 9'h071}, '{8'hff, 8'hbf, 9'h1f9}};
   assign outs = {fast, lp, amp, op, pd, hold, cal};
   always #5 sys_clk_in = ~sys_clk_in;
   acm_ctrl_top dut_u (
      .sys_clk_in         (sys_clk_in),
      .arst_n_in          (arst_n_in),
      .ce_in              (ce_in),
      .addr_in            (addr_in),
      .wr_data_in         (wr_data_in),
      .wr_in              (wr_in),
      .rd_in              (rd_in),
      .prim_result_wr_in  (ev[0]),
      .aux_result_wr_in   (ev[1]),
      .prim_result_rd_in  (ev[2]),
      .prim_overrange_in  (ev[3]),
      .prim_threshold_in  (ev[4]),
      .aux_result_rd_in   (ev[5]),
      .accum_threshold_in (ev[6]),
      .cal_done_in        (ev[7]),
      .cal_result_in      (cal_res),
      .rd_data_out        (rd_data_out),
      .irq_out            (irq_out),
      .conv_clk_fast_out  (fast),
      .lp_enable_out      (lp),
      .amp_off_out        (amp),
      .op_mode_out        (op),
      .powerdown_out      (pd),
      .adc_hold_out       (hold),
      .cal_active_out     (cal)
   );
   // ------------------------------------------------------------------
   // Bus cycles, event pulses and comparisons
   // ------------------------------------------------------------------
   task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      wr_in      <= 1'b1;
      addr_in    <= a;
      wr_data_in <= d;
      @(posedge sys_clk_in);
      wr_in      <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe edge.
   task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge sys_clk_in);
      rd_in   <= 1'b0;
      #1;
      d = rd_data_out;
   endtask
   task automatic pulse(input logic [7:0] m);
      @(posedge sys_clk_in);
      ev <= m;
      @(posedge sys_clk_in);
      ev <= 8'h00;
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk_in);
      #1;
   endtask
   task automatic check_word(input string n, input logic [31:0] e,
                             input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic check_bit(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic read_check(input string n, input logic [31:0] a,
                             input logic [31:0] e);
      logic [31:0] d;
      bus_read(a, d);
      check_word(n, e, d);
   endtask
   // Write and read back with no idle cycle between the two strobes.
   task automatic wr_rd_check(input string n, input logic [31:0] a,
                              input logic [7:0] d, input logic [7:0] e);
      @(posedge sys_clk_in);
      wr_in      <= 1'b1;
      addr_in    <= a;
      wr_data_in <= {24'h0, d};
      @(posedge sys_clk_in);
      wr_in      <= 1'b0;
      rd_in      <= 1'b1;
      @(posedge sys_clk_in);
      rd_in      <= 1'b0;
      #1;
      check_word(n, {24'h0, e}, rd_data_out);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Watchdog: a hang counts as a mismatch and ends the run.
   // ------------------------------------------------------------------
   initial
   begin
      repeat (50000) @(posedge sys_clk_in);
      n_errors++;
      tally_and_finish();
   end
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      #1;
      check_word("reset outs", 32'h01a, {23'h0, outs});
      check_bit("reset irq", 1'b0, irq_out);
      read_check("reset enable", `ACM_ADDR_ENABLE, 32'h0);
      read_check("reset mode", `ACM_ADDR_MODE, 32'h03);
      foreach (rows[i])
      begin
         wr_rd_check("mode rb", `ACM_ADDR_MODE, rows[i].wv, rows[i].rv);
         check_word("mode outs", {23'h0, rows[i].ov}, {23'h0, outs});
      end
      bus_write(`ACM_ADDR_MODE, 32'h03);
      wr_rd_check("enable rb", `ACM_ADDR_ENABLE, 8'hff, 8'h5b);
      foreach (src[i])
      begin
         bus_write(`ACM_ADDR_ENABLE, 32'h5b & ~(32'h1 << src[i]));
         pulse(8'h01 << src[i]);
         settle();
         check_bit("irq masked", 1'b0, irq_out);
         read_check("status", `ACM_ADDR_STATUS, 32'h1 << src[i]);
         bus_write(`ACM_ADDR_ENABLE, 32'h1 << src[i]);
         settle();
         check_bit("irq enabled", 1'b1, irq_out);
         bus_write(`ACM_ADDR_CLEAR, 32'h1 << src[i]);
         settle();
         check_bit("irq cleared", 1'b0, irq_out);
      end
      // Single conversion returns to idle; ready clears on result read.
      bus_write(`ACM_ADDR_MODE, 32'h02);
      pulse(8'h01);
      settle();
      read_check("single idle", `ACM_ADDR_MODE, 32'h03);
      read_check("prim rdy", `ACM_ADDR_STATUS, 32'h1);
      pulse(8'h04);
      settle();
      read_check("prim rd clr", `ACM_ADDR_STATUS, 32'h0);
      pulse(8'h02);
      pulse(8'h04);
      settle();
      read_check("aux kept", `ACM_ADDR_STATUS, 32'h2);
      pulse(8'h20);
      pulse(8'h04);
      settle();
      read_check("aux clr", `ACM_ADDR_STATUS, 32'h0);
      // Calibration end stores the result and returns to idle.
      bus_write(`ACM_ADDR_MODE, 32'h84);
      cal_res <= 24'h123456;
      pulse(8'h80);
      settle();
      read_check("cal idle", `ACM_ADDR_MODE, 32'h83);
      read_check("cal flags", `ACM_ADDR_STATUS, 32'h101);
      read_check("cal result", `ACM_ADDR_CALRES, 32'h123456);
      check_bit("cal hold", 1'b1, hold);
      check_bit("cal active", 1'b0, cal);
      bus_write(`ACM_ADDR_CLEAR, 32'h1ff);
      read_check("clear rd", `ACM_ADDR_CLEAR, 32'h0);
      read_check("status zero", `ACM_ADDR_STATUS, 32'h0);
      // Unmapped and frozen accesses leave the registers alone.
      bus_write(32'hffff0500, 32'hff);
      read_check("unmapped", 32'hffff0500, 32'h0);
      @(posedge sys_clk_in);
      ce_in <= 1'b0;
      bus_write(`ACM_ADDR_ENABLE, 32'h5b);
      @(posedge sys_clk_in);
      ce_in <= 1'b1;
      read_check("ce frozen", `ACM_ADDR_ENABLE, 32'h40);
      // Second reset in mid-run with an interrupt pending.
      bus_write(`ACM_ADDR_ENABLE, 32'h01);
      bus_write(`ACM_ADDR_MODE, 32'hb9);
      pulse(8'h01);
      settle();
      check_bit("irq pend", 1'b1, irq_out);
      @(posedge sys_clk_in);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      #1;
      check_bit("rst irq", 1'b0, irq_out);
      check_word("rst op", 32'h3, {29'h0, op});
      @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      read_check("rst enable", `ACM_ADDR_ENABLE, 32'h0);
      read_check("rst mode", `ACM_ADDR_MODE, 32'h03);
      read_check("rst status", `ACM_ADDR_STATUS, 32'h0);
      tally_and_finish();
   end
endmodule // acm_ctrl_top_tb_top
